/* core/sgc_defs.vh */
`ifndef SGC_DEFS_VH
`define SGC_DEFS_VH

`define SGC_ADDR_W          12
`define SGC_CTL_OFFSET      12'h404
`define SGC_DATA_W          32

`define SGC_BIT_FULL_RST    0
`define SGC_BIT_WARM_RST    1
`define SGC_BIT_HOLD        2
`define SGC_BIT_LOCK_WE     3
`define SGC_BIT_PWR_UL      4
`define SGC_BIT_LD_DIS      5
`define SGC_BIT_EE_SKIP     6
`define SGC_BIT_ORD_OVR     7

`define SGC_RST_BIT         1'h0
`define SGC_HOLD_RST        1'h0
`define SGC_RSVD_W          24
`define SGC_RSVD_VAL        24'h000000

`endif

/* core/sgc_write_gate.v */
`timescale 1ns/10ps
`include "sgc_defs.vh"

// Write qualifier for lock-protected fields: a lock-protected bit only
// accepts a write while the unlock bit is set.
module sgc_write_gate (
    write_hit,
    lock_open,
    field_locked,
    write_ok
);
    input  wire write_hit;
    input  wire lock_open;
    input  wire field_locked;
    output wire write_ok;

    assign write_ok = write_hit & (lock_open | ~field_locked);
endmodule // sgc_write_gate

/* core/sgc_switch_control.v */
// Contract
// - A written one on full_reset_trigger starts a full reset; reads zero.
// - A written one on warm_reset_trigger starts a hot reset; reads zero.
// - While reset_hold is set, all but the SMBus interface stays in reset.
// - In reset_hold the SMBus slave can still write and set up registers.
// - An EEPROM load error or the EEPROM contents set reset_hold.
// - Lock-protected fields update only while lockable_write_enable is set.
// - lockable_write_enable resets zero; a reset operation sets it.
// - power_budget_unlock set makes power budget values writable.
// - linkdown_warm_reset_disable blocks only the DL_Down hot reset cause.
// - warm_reset_eeprom_skip drops the EEPROM load step of a hot reset.
// - ordering_override forces strict order, ignoring relaxed ordering.
// - Sticky fields keep their value across a hot reset.
`timescale 1ns/10ps
`include "sgc_defs.vh"

module sgc_switch_control (
    clock,
    reset,
    warm_reset_active,
    reset_op_active,
    smbus_sel,
    reg_write,
    reg_read,
    reg_addr,
    reg_wdata,
    ee_init_error,
    ee_set_hold,
    upstream_dl_down,
    reg_rdata,
    full_reset_req,
    warm_reset_req,
    hold_core_reset,
    lock_protected_field_we,
    power_budget_value_we,
    linkdown_warm_reset_req,
    warm_reset_eeprom_skip,
    ordering_override
);
    input  wire                     clock;
    input  wire                     reset;
    input  wire                     warm_reset_active;
    input  wire                     reset_op_active;
    input  wire                     smbus_sel;
    input  wire                     reg_write;
    input  wire                     reg_read;
    input  wire [`SGC_ADDR_W-1:0]   reg_addr;
    input  wire [`SGC_DATA_W-1:0]   reg_wdata;
    input  wire                     ee_init_error;
    input  wire                     ee_set_hold;
    input  wire                     upstream_dl_down;
    output reg  [`SGC_DATA_W-1:0]   reg_rdata;
    output reg                      full_reset_req;
    output reg                      warm_reset_req;
    output reg                      hold_core_reset;
    output reg                      lock_protected_field_we;
    output reg                      power_budget_value_we;
    output reg                      linkdown_warm_reset_req;
    output reg                      warm_reset_eeprom_skip;
    output reg                      ordering_override;

    reg  reset_hold;
    reg  lockable_write_enable;
    reg  power_budget_unlock;
    reg  linkdown_warm_reset_disable;
    reg  warm_reset_eeprom_skip_bit;
    reg  ordering_override_bit;
    reg  dl_down_q;

    // Next values, settled combinationally and registered below
    reg  next_reset_hold;
    reg  next_lockable_write_enable;
    reg  next_power_budget_unlock;
    reg  next_linkdown_warm_reset_disable;
    reg  next_warm_reset_eeprom_skip_bit;
    reg  next_ordering_override_bit;
    reg  next_full_reset_req;
    reg  next_warm_reset_req;
    reg  next_linkdown_warm_reset_req;
    reg  [`SGC_DATA_W-1:0] next_reg_rdata;

    wire hit;
    wire wr_hit;
    wire pwr_ul_ok;
    wire [`SGC_DATA_W-1:0] read_word;
    wire [`SGC_DATA_W-1:0] w;

    // Register decode; only the one control word lives in this block
    function ctl_select;
        input [`SGC_ADDR_W-1:0] addr;
        begin
            ctl_select = (addr == `SGC_CTL_OFFSET);
        end
    endfunction

    // Shared by both trigger bits: a written zero never raises a request
    function trigger_pulse;
        input                   write_ok;
        input [`SGC_DATA_W-1:0] data;
        input integer           pos;
        begin
            trigger_pulse = write_ok & data[pos];
        end
    endfunction

    // Core writes are blocked while held; the SMBus path always gets through
    assign hit    = ctl_select(reg_addr);
    assign wr_hit = hit & reg_write & (~reset_hold | smbus_sel);
    assign w      = reg_wdata;

    sgc_write_gate u_pwr_gate (
        .write_hit    (wr_hit),
        .lock_open    (lockable_write_enable),
        .field_locked (1'b1),
        .write_ok     (pwr_ul_ok)
    );

    // Trigger bits read as zero; reserved bits too
    assign read_word = {`SGC_RSVD_VAL,
                        ordering_override_bit,
                        warm_reset_eeprom_skip_bit,
                        linkdown_warm_reset_disable,
                        power_budget_unlock,
                        lockable_write_enable,
                        reset_hold,
                        `SGC_RST_BIT,
                        `SGC_RST_BIT};

    // Loader events win over a same-cycle write of the hold bit
    always @* begin
        next_reset_hold = reset_hold;
        if (ee_init_error | ee_set_hold) begin
            next_reset_hold = 1'b1;
        end else if (wr_hit) begin
            next_reset_hold = w[`SGC_BIT_HOLD];
        end
    end

    // The reset sequence reopens the lock so the loader can fill fields
    always @* begin
        next_lockable_write_enable = lockable_write_enable;
        if (reset_op_active) begin
            next_lockable_write_enable = 1'b1;
        end else if (wr_hit) begin
            next_lockable_write_enable = w[`SGC_BIT_LOCK_WE];
        end
    end

    // An unlock in the same word does not open the gate yet
    always @* begin
        next_power_budget_unlock = power_budget_unlock;
        if (pwr_ul_ok) begin
            next_power_budget_unlock = w[`SGC_BIT_PWR_UL];
        end
    end

    always @* begin
        next_linkdown_warm_reset_disable = linkdown_warm_reset_disable;
        next_warm_reset_eeprom_skip_bit  = warm_reset_eeprom_skip_bit;
        next_ordering_override_bit       = ordering_override_bit;
        if (wr_hit) begin
            next_linkdown_warm_reset_disable = w[`SGC_BIT_LD_DIS];
            next_warm_reset_eeprom_skip_bit  = w[`SGC_BIT_EE_SKIP];
            next_ordering_override_bit       = w[`SGC_BIT_ORD_OVR];
        end
    end

    // Request pulses and read data
    always @* begin
        next_full_reset_req = trigger_pulse(wr_hit, w,
                                            `SGC_BIT_FULL_RST);
        next_warm_reset_req = trigger_pulse(wr_hit, w,
                                            `SGC_BIT_WARM_RST);
        if (reg_read & hit) begin
            next_reg_rdata = read_word;
        end else begin
            next_reg_rdata = {`SGC_DATA_W{1'b0}};
        end
        // Only the rising entry to DL_Down counts as a reset cause
        next_linkdown_warm_reset_req = upstream_dl_down & ~dl_down_q &
                                       ~linkdown_warm_reset_disable;
    end

    // Sticky fields ignore warm_reset_active; only the chip reset clears them
    always @(posedge clock) begin
        if (reset) begin
            reset_hold                  <= `SGC_HOLD_RST;
            lockable_write_enable       <= 1'b0;
            power_budget_unlock         <= 1'b0;
            linkdown_warm_reset_disable <= 1'b0;
            warm_reset_eeprom_skip_bit  <= 1'b0;
            ordering_override_bit       <= 1'b0;
        end else begin
            reset_hold                  <= next_reset_hold;
            lockable_write_enable       <= next_lockable_write_enable;
            power_budget_unlock         <= next_power_budget_unlock;
            linkdown_warm_reset_disable <= next_linkdown_warm_reset_disable;
            warm_reset_eeprom_skip_bit  <= next_warm_reset_eeprom_skip_bit;
            ordering_override_bit       <= next_ordering_override_bit;
        end
    end

    always @(posedge clock) begin
        if (reset) begin
            reg_rdata               <= {`SGC_DATA_W{1'b0}};
            full_reset_req          <= 1'b0;
            warm_reset_req          <= 1'b0;
            hold_core_reset         <= 1'b0;
            lock_protected_field_we <= 1'b0;
            power_budget_value_we   <= 1'b0;
            linkdown_warm_reset_req <= 1'b0;
            warm_reset_eeprom_skip  <= 1'b0;
            ordering_override       <= 1'b0;
            dl_down_q               <= 1'b0;
        end else begin
            reg_rdata               <= next_reg_rdata;
            full_reset_req          <= next_full_reset_req;
            warm_reset_req          <= next_warm_reset_req;
            hold_core_reset         <= reset_hold;
            lock_protected_field_we <= lockable_write_enable;
            power_budget_value_we   <= power_budget_unlock;
            dl_down_q               <= upstream_dl_down;
            linkdown_warm_reset_req <= next_linkdown_warm_reset_req;
            warm_reset_eeprom_skip  <= warm_reset_eeprom_skip_bit;
            ordering_override       <= ordering_override_bit;
        end
    end
endmodule // sgc_switch_control

/* bench/sgc_chk.sv */
`timescale 1ns/10ps
module sgc_chk (
    input wire        clock,
    input wire        reset,
    input wire        reset_op_active,
    input wire        smbus_sel,
    input wire        reg_write,
    input wire        reg_read,
    input wire [11:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire        ee_init_error,
    input wire        ee_set_hold,
    input wire [31:0] reg_rdata,
    input wire        full_reset_req,
    input wire        warm_reset_req,
    input wire        hold_core_reset,
    input wire        lock_protected_field_we,
    input wire        ordering_override
);
    reg  ee_q;
    wire w0;
    // Hold output lags its bit, so skip writes right after a loader hold
    always @(posedge clock) ee_q <= ee_init_error | ee_set_hold;
    assign w0 = reg_write && reg_addr == 12'h404
                && (smbus_sel || !hold_core_reset && !ee_q);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    chk_full_req: assert property (
        w0 && reg_wdata[0] |=> full_reset_req) else $error("no full pulse");
    chk_full_single: assert property (
        full_reset_req && !(w0 && reg_wdata[0]) |=> !full_reset_req)
        else $error("full pulse too long");
    chk_warm_req: assert property (
        w0 && reg_wdata[1] |=> warm_reset_req) else $error("no warm pulse");
    chk_trig_read_zero: assert property (
        reg_read && reg_addr == 12'h404 |=> reg_rdata[1:0] == 2'h0
        && reg_rdata[31:8] == 24'h0) else $error("trigger bits read back");
    chk_hold_set: assert property (
        ee_init_error || ee_set_hold |-> ##2 hold_core_reset)
        else $error("hold not set");
    chk_unlock_set: assert property (
        reset_op_active |-> ##2 lock_protected_field_we)
        else $error("no unlock");
    chk_lock_write: assert property (
        w0 && reg_wdata[3] |-> ##2 lock_protected_field_we)
        else $error("unlock write lost");
    chk_order_write: assert property (
        w0 |-> ##2 ordering_override == $past(reg_wdata[7], 2))
        else $error("ordering bit wrong");
    cover property (full_reset_req && warm_reset_req);
    cover property (hold_core_reset && w0 && smbus_sel);
    cover property (lock_protected_field_we && ordering_override);
endmodule // sgc_chk

bind sgc_switch_control sgc_chk i_chk (.*);

/* bench/switch_global_control_reg_bench.sv */
`timescale 1ns/10ps
module switch_global_control_reg_bench;
    reg         clock = 0, reset = 1, warm_reset_active = 0;
    reg         reset_op_active = 0, smbus_sel = 0, reg_write = 0;
    reg         reg_read = 0, ee_init_error = 0, ee_set_hold = 0;
    reg         upstream_dl_down = 0;
    reg  [11:0] reg_addr = 12'h404;
    reg  [31:0] reg_wdata = 32'h0, n;
    wire [31:0] reg_rdata;
    wire        full_reset_req, warm_reset_req, hold_core_reset;
    wire        lock_protected_field_we, power_budget_value_we;
    wire        linkdown_warm_reset_req, warm_reset_eeprom_skip;
    wire        ordering_override;
    wire [3:0]  levels = {lock_protected_field_we, power_budget_value_we,
                          warm_reset_eeprom_skip, ordering_override};
    integer     err_count = 0, total_checks = 0, i;
    sgc_switch_control i_dut (
        .clock                   (clock),
        .reset                   (reset),
        .warm_reset_active       (warm_reset_active),
        .reset_op_active         (reset_op_active),
        .smbus_sel               (smbus_sel),
        .reg_write               (reg_write),
        .reg_read                (reg_read),
        .reg_addr                (reg_addr),
        .reg_wdata               (reg_wdata),
        .ee_init_error           (ee_init_error),
        .ee_set_hold             (ee_set_hold),
        .upstream_dl_down        (upstream_dl_down),
        .reg_rdata               (reg_rdata),
        .full_reset_req          (full_reset_req),
        .warm_reset_req          (warm_reset_req),
        .hold_core_reset         (hold_core_reset),
        .lock_protected_field_we (lock_protected_field_we),
        .power_budget_value_we   (power_budget_value_we),
        .linkdown_warm_reset_req (linkdown_warm_reset_req),
        .warm_reset_eeprom_skip  (warm_reset_eeprom_skip),
        .ordering_override       (ordering_override)
    );
    always #2.5 clock = ~clock;
    task cmp(input [63:0] nm, input [31:0] e, input [31:0] g);
        total_checks = total_checks + 1;
        if (g !== e) begin
            err_count = err_count + 1;
            $display("CHECK FAILED %0s exp %h got %h", nm, e, g);
        end
    endtask
    task wr(input [11:0] a, input [31:0] d, input s);
        @(posedge clock);
        {reg_write, smbus_sel, reg_addr, reg_wdata} <= {1'b1, s, a, d};
        @(posedge clock);
        reg_write <= 0;
        #1 cmp("trig", {d[1:0] & {2{a == 12'h404}}},
               {warm_reset_req, full_reset_req});
    endtask
    task rd(input [11:0] a, input [31:0] e);
        @(posedge clock);
        {reg_read, reg_addr} <= {1'b1, a};
        @(posedge clock);
        reg_read <= 0;
        #1 cmp("rdata", e, reg_rdata);
    endtask
    task dl(input [31:0] e);
        n = 0;
        @(posedge clock);
        upstream_dl_down <= 1;
        for (i = 0; i < 4; i = i + 1) begin
            @(posedge clock);
            if (i == 3)
                upstream_dl_down <= 0;
            #1 n = n + linkdown_warm_reset_req;
        end
        cmp("linkdown", e, n);
    endtask
    task print_verdict;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clock);
        reset <= 0;
        rd(12'h404, 0);
        wr(12'h404, 32'h3, 0);
        rd(12'h404, 0);
        wr(12'h408, 32'hff, 0);
        rd(12'h408, 0);
        wr(12'h404, 32'hf8, 0);
        rd(12'h404, 32'he8);
        wr(12'h404, 32'hf8, 0);
        rd(12'h404, 32'hf8);
        cmp("levels", 4'hf, levels);
        dl(0);
        wr(12'h404, 32'h18, 0);
        dl(1);
        for (i = 1; i < 3; i = i + 1) begin
            @(posedge clock);
            {ee_set_hold, ee_init_error} <= i[1:0];
            @(posedge clock);
            {ee_set_hold, ee_init_error} <= 2'h0;
            rd(12'h404, 32'h1c);
            cmp("hold", 1, hold_core_reset);
            wr(12'h404, 32'h0, 0);
            rd(12'h404, 32'h1c);
            wr(12'h404, 32'h18, 1);
            rd(12'h404, 32'h18);
        end
        @(posedge clock);
        warm_reset_active <= 1;
        @(posedge clock);
        warm_reset_active <= 0;
        rd(12'h404, 32'h18);
        wr(12'h404, 32'h0, 0);
        @(posedge clock);
        reset_op_active <= 1;
        @(posedge clock);
        reset_op_active <= 0;
        rd(12'h404, 32'h8);
        cmp("levels", 4'h8, levels);
        print_verdict;
    end
endmodule // switch_global_control_reg_bench
